// ---- logic/ecc_pkg.sv ----
// Shared constants and carrier types for the excitation current control block
package ecc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CSC_ADDR = 8'hd5;
  localparam logic [7:0] CSC_RESET = 8'h00;

  // ==========================================================
  // Field positions in the control register
  localparam int BIT_SOURCE_ONE_ON = 0;
  localparam int BIT_SOURCE_TWO_ON = 1;
  localparam int BIT_SOURCE_ONE_PIN = 2;
  localparam int BIT_SOURCE_TWO_PIN = 3;
  localparam int BIT_MAIN_CORR = 4;
  localparam int BIT_AUX_CORR = 5;
  localparam int BIT_BURNOUT = 6;
  localparam int BIT_RESERVED = 7;

  // ==========================================================
  // Analog and datapath figures
  localparam logic [9:0] SOURCE_UA = 10'h0c8;
  localparam int CONV_W = 16;
  localparam int CAL_W = 16;
  localparam int CAL_FRAC = 15;
  localparam int NUM_CONV = 2;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic burnout_on;
    logic aux_conv_current_correction;
    logic main_conv_current_correction;
    logic source_two_pin_select;
    logic source_one_pin_select;
    logic source_two_on;
    logic source_one_on;
  } ecc_csc_s;

  typedef struct packed {
    logic valid;
    logic [CONV_W-1:0] data;
  } ecc_conv_s;

  typedef struct packed {
    logic from_one;
    logic from_two;
    logic [9:0] current_ua;
  } ecc_pin_s;

  typedef struct packed {
    ecc_csc_s csc;
    logic [7:0] rdata;
    logic rd_valid;
  } ecc_ctrl_state_s;

endpackage : ecc_pkg

// ---- logic/ecc_router.sv ----
// Routes the two excitation sources onto the two excitation pins
`timescale 1ns/1ns
module ecc_router
(
  input logic clk_sys,
  input logic resetn,
  input ecc_pkg::ecc_csc_s csc,
  output ecc_pkg::ecc_pin_s first_excitation_pin,
  output ecc_pkg::ecc_pin_s second_excitation_pin
);

  // ==========================================================
  // Pin selection per source
  logic pin_of_one;
  logic pin_of_two;
  logic [1:0] one_here;
  logic [1:0] two_here;
  ecc_pkg::ecc_pin_s [1:0] pin_r;
  ecc_pkg::ecc_pin_s [1:0] pin_nxt;

  // Index 0 is the first pin, 1 the second
  assign pin_of_one = csc.source_one_pin_select;
  assign pin_of_two = ~csc.source_two_pin_select;

  // ==========================================================
  // Per-pin switch terms; no exclusion, so both may land on one pin
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    assign one_here[p] = csc.source_one_on & (pin_of_one == 1'(p));
    assign two_here[p] = csc.source_two_on & (pin_of_two == 1'(p));
  end

  // Current sums add, giving 400 uA on a shared pin
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pin_nxt[i].from_one = one_here[i];
      pin_nxt[i].from_two = two_here[i];
      pin_nxt[i].current_ua = (one_here[i] ? ecc_pkg::SOURCE_UA : 10'h000)
                            + (two_here[i] ? ecc_pkg::SOURCE_UA : 10'h000);
    end
  end

  // Registered so the analog switches see glitch-free levels
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      pin_r <= '0;
    else
      pin_r <= pin_nxt;
  end

  assign first_excitation_pin = pin_r[0];
  assign second_excitation_pin = pin_r[1];

endmodule : ecc_router

// ---- logic/ecc_scaler.sv ----
// Optional calibration-word scaling of one converter result stream
`timescale 1ns/1ns
module ecc_scaler #(
  parameter int DATA_W = 16,
  parameter int CAL_W = 16,
  parameter int FRAC = 15
)
(
  input logic clk_sys,
  input logic resetn,
  input logic correct_en,
  input logic [CAL_W-1:0] cal_word,
  input logic in_valid,
  input logic [DATA_W-1:0] in_data,
  output logic out_valid,
  output logic [DATA_W-1:0] out_data
);

  // ==========================================================
  // State and product
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } ecc_scl_state_s;

  ecc_scl_state_s st_r;
  ecc_scl_state_s st_nxt;
  logic [DATA_W+CAL_W-1:0] prod;
  logic [DATA_W+CAL_W-1:0] shifted;

  // Cal word is fixed point with FRAC fraction bits; overflow saturates
  always_comb
  begin
    prod = (DATA_W+CAL_W)'(in_data) * (DATA_W+CAL_W)'(cal_word);
    shifted = prod >> FRAC;
    st_nxt = st_r;
    st_nxt.valid = in_valid;
    if (in_valid)
    begin
      if (!correct_en)
        st_nxt.data = in_data;
      else if (|shifted[DATA_W+CAL_W-1:DATA_W])
        st_nxt.data = '1;
      else
        st_nxt.data = shifted[DATA_W-1:0];
    end
  end

  // One cycle of latency whether or not scaling is on
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign out_valid = st_r.valid;
  assign out_data = st_r.data;

endmodule : ecc_scaler

// ---- logic/ecc_ctrl.sv ----
// Current-source control register with source routing and result correction
`timescale 1ns/1ns
// Function
// - Register clears to zero at reset
// - Bit 7 reserved, no control effect
// - Bit 6 enables both burnout currents together
// - Bit 5 scales auxiliary converter result
// - Bit 4 scales main converter result
// - Bit 3 set routes source two first
// - Bit 2 set routes source one second
// - Bit 1 switches source two on
// - Bit 0 switches source one on
// - Both sources may share one pin
module ecc_ctrl
(
  input logic clk_sys,
  input logic resetn,
  input logic [7:0] sfr_addr,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_rd_valid,
  output logic sfr_hit,
  input ecc_pkg::ecc_conv_s main_conv_in,
  input ecc_pkg::ecc_conv_s aux_conv_in,
  input logic [ecc_pkg::CAL_W-1:0] main_cal_word,
  input logic [ecc_pkg::CAL_W-1:0] aux_cal_word,
  output ecc_pkg::ecc_conv_s main_conv_out,
  output ecc_pkg::ecc_conv_s aux_conv_out,
  output logic source_one_on,
  output logic source_two_on,
  output logic source_one_pin_select,
  output logic source_two_pin_select,
  output logic main_conv_current_correction,
  output logic aux_conv_current_correction,
  output logic burnout_pos_on,
  output logic burnout_neg_on,
  output ecc_pkg::ecc_pin_s first_excitation_pin,
  output ecc_pkg::ecc_pin_s second_excitation_pin
);

  // ==========================================================
  // Register state
  ecc_pkg::ecc_ctrl_state_s st_r;
  ecc_pkg::ecc_ctrl_state_s st_nxt;
  logic [7:0] rd_word;
  logic wr_hit;
  logic rd_hit;

  // Only one address is decoded; others are left to other SFRs
  assign sfr_hit = (sfr_addr == ecc_pkg::CSC_ADDR);
  assign wr_hit = sfr_wr & sfr_hit;
  assign rd_hit = sfr_rd & sfr_hit;

  // ==========================================================
  // Read image: reserved bit always reads zero
  always_comb
  begin
    rd_word = 8'h00;
    rd_word[ecc_pkg::BIT_SOURCE_ONE_ON] = st_r.csc.source_one_on;
    rd_word[ecc_pkg::BIT_SOURCE_TWO_ON] = st_r.csc.source_two_on;
    rd_word[ecc_pkg::BIT_SOURCE_ONE_PIN] = st_r.csc.source_one_pin_select;
    rd_word[ecc_pkg::BIT_SOURCE_TWO_PIN] = st_r.csc.source_two_pin_select;
    rd_word[ecc_pkg::BIT_MAIN_CORR] = st_r.csc.main_conv_current_correction;
    rd_word[ecc_pkg::BIT_AUX_CORR] = st_r.csc.aux_conv_current_correction;
    rd_word[ecc_pkg::BIT_BURNOUT] = st_r.csc.burnout_on;
    rd_word[ecc_pkg::BIT_RESERVED] = 1'b0;
  end

  // ==========================================================
  // Next-state: writes land on the next edge, reads see old value
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rd_valid = rd_hit;
    if (rd_hit)
    begin
      st_nxt.rdata = rd_word;
    end
    if (wr_hit)
    begin
      // Bit 7 is dropped here, so it steers nothing
      st_nxt.csc.source_one_on = sfr_wdata[ecc_pkg::BIT_SOURCE_ONE_ON];
      st_nxt.csc.source_two_on = sfr_wdata[ecc_pkg::BIT_SOURCE_TWO_ON];
      st_nxt.csc.source_one_pin_select = sfr_wdata[ecc_pkg::BIT_SOURCE_ONE_PIN];
      st_nxt.csc.source_two_pin_select = sfr_wdata[ecc_pkg::BIT_SOURCE_TWO_PIN];
      st_nxt.csc.main_conv_current_correction = sfr_wdata[ecc_pkg::BIT_MAIN_CORR];
      st_nxt.csc.aux_conv_current_correction = sfr_wdata[ecc_pkg::BIT_AUX_CORR];
      st_nxt.csc.burnout_on = sfr_wdata[ecc_pkg::BIT_BURNOUT];
    end
  end

  // Synchronous reset puts every control off
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      st_r.csc <= ecc_pkg::CSC_RESET[6:0];
      st_r.rdata <= 8'h00;
      st_r.rd_valid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Register read port
  assign sfr_rdata = st_r.rdata;
  assign sfr_rd_valid = st_r.rd_valid;

  // ==========================================================
  // Static control levels straight from the register flops
  assign source_one_on = st_r.csc.source_one_on;
  assign source_two_on = st_r.csc.source_two_on;
  assign source_one_pin_select = st_r.csc.source_one_pin_select;
  assign source_two_pin_select = st_r.csc.source_two_pin_select;
  assign main_conv_current_correction = st_r.csc.main_conv_current_correction;
  assign aux_conv_current_correction = st_r.csc.aux_conv_current_correction;

  // One bit feeds both burnout sources so they never split
  assign burnout_pos_on = st_r.csc.burnout_on;
  assign burnout_neg_on = st_r.csc.burnout_on;

  // ==========================================================
  // Excitation pin routing, one cycle behind the register
  ecc_router u_router
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .csc(st_r.csc),
    .first_excitation_pin(first_excitation_pin),
    .second_excitation_pin(second_excitation_pin)
  );

  // ==========================================================
  // Converter result correction, index 0 main, 1 auxiliary
  ecc_pkg::ecc_conv_s conv_in_a [ecc_pkg::NUM_CONV];
  ecc_pkg::ecc_conv_s conv_out_a [ecc_pkg::NUM_CONV];
  logic [ecc_pkg::CAL_W-1:0] cal_a [ecc_pkg::NUM_CONV];
  logic corr_a [ecc_pkg::NUM_CONV];

  assign conv_in_a[0] = main_conv_in;
  assign conv_in_a[1] = aux_conv_in;
  assign cal_a[0] = main_cal_word;
  assign cal_a[1] = aux_cal_word;
  assign corr_a[0] = st_r.csc.main_conv_current_correction;
  assign corr_a[1] = st_r.csc.aux_conv_current_correction;

  // Same scaler per converter; the enable is sampled per result
  for (genvar c = 0; c < ecc_pkg::NUM_CONV; c++)
  begin : g_conv
    ecc_scaler #(
      .DATA_W(ecc_pkg::CONV_W),
      .CAL_W(ecc_pkg::CAL_W),
      .FRAC(ecc_pkg::CAL_FRAC)
    ) u_scaler
    (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .correct_en(corr_a[c]),
      .cal_word(cal_a[c]),
      .in_valid(conv_in_a[c].valid),
      .in_data(conv_in_a[c].data),
      .out_valid(conv_out_a[c].valid),
      .out_data(conv_out_a[c].data)
    );
  end

  assign main_conv_out = conv_out_a[0];
  assign aux_conv_out = conv_out_a[1];

endmodule : ecc_ctrl

// ---- sim/ecc_ctrl_properties.sv ----
// Port-level checks for the current-source control register block
`timescale 1ns/1ns
module ecc_ctrl_properties
(
  input logic clk_sys,
  input logic resetn,
  input logic sfr_wr,
  input logic sfr_rd,
  input logic [7:0] sfr_wdata,
  input logic [7:0] sfr_rdata,
  input logic sfr_rd_valid,
  input logic sfr_hit,
  input ecc_pkg::ecc_conv_s main_conv_in,
  input ecc_pkg::ecc_conv_s main_conv_out,
  input logic source_one_on,
  input logic source_two_on,
  input logic source_one_pin_select,
  input logic source_two_pin_select,
  input logic main_conv_current_correction,
  input logic aux_conv_current_correction,
  input logic burnout_pos_on,
  input logic burnout_neg_on,
  input ecc_pkg::ecc_pin_s first_excitation_pin
);
  // ==========================================================
  // Helper terms: control bits in register order, bus hits
  wire [6:0] csc = {burnout_pos_on, aux_conv_current_correction, main_conv_current_correction,
    source_two_pin_select, source_one_pin_select, source_two_on, source_one_on};
  wire wh = sfr_wr && sfr_hit;
  wire rh = sfr_rd && sfr_hit;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Assertions
  // Reset check may not be disabled by the reset it watches
  a_reset_clears: assert property (disable iff (1'b0) !resetn |=> csc == 7'h00 && !sfr_rd_valid)
    else $error("reset left a control output set");
  a_write_enables: assert property (wh |=> csc[1:0] == $past(sfr_wdata[1:0]))
    else $error("source enables do not follow write");
  a_write_pins: assert property (wh |=> csc[3:2] == $past(sfr_wdata[3:2]))
    else $error("pin selects do not follow write");
  a_write_corr: assert property (wh |=> csc[6:4] == $past(sfr_wdata[6:4]))
    else $error("burnout or correction bits do not follow write");
  a_burnout_pair: assert property (burnout_pos_on == burnout_neg_on)
    else $error("burnout outputs differ");
  a_read_old: assert property (rh |=> sfr_rd_valid && sfr_rdata == {1'b0, $past(csc)})
    else $error("read data wrong");
  a_hold_state: assert property (!wh |=> $stable(csc))
    else $error("control changed without write");
  a_no_read: assert property (!rh |=> !sfr_rd_valid)
    else $error("read answer without read hit");
  a_pin_route: assert property (1'b1 |=> first_excitation_pin.from_one == $past(csc[0] & ~csc[2])
    && first_excitation_pin.from_two == $past(csc[1] & csc[3])
    && first_excitation_pin.current_ua == (first_excitation_pin.from_one ? 10'h0c8 : 10'h000)
    + (first_excitation_pin.from_two ? 10'h0c8 : 10'h000))
    else $error("first pin routing wrong");
  a_main_bypass: assert property (main_conv_in.valid && !main_conv_current_correction
    |=> main_conv_out.valid && main_conv_out.data == $past(main_conv_in.data))
    else $error("main result not passed through");

  // ==========================================================
  // Coverage of the main scenarios
  c_write: cover property (wh);
  c_read: cover property (rh);
  c_shared_pin: cover property (first_excitation_pin.current_ua == 10'h190);
endmodule : ecc_ctrl_properties

bind ecc_ctrl ecc_ctrl_properties u_props
(
  .clk_sys(clk_sys),
  .resetn(resetn),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .sfr_rd_valid(sfr_rd_valid),
  .sfr_hit(sfr_hit),
  .main_conv_in(main_conv_in),
  .main_conv_out(main_conv_out),
  .source_one_on(source_one_on),
  .source_two_on(source_two_on),
  .source_one_pin_select(source_one_pin_select),
  .source_two_pin_select(source_two_pin_select),
  .main_conv_current_correction(main_conv_current_correction),
  .aux_conv_current_correction(aux_conv_current_correction),
  .burnout_pos_on(burnout_pos_on),
  .burnout_neg_on(burnout_neg_on),
  .first_excitation_pin(first_excitation_pin)
);

// ---- sim/test_excitation_current_control_reg.sv ----
// Self-checking bench for the current-source control register block
`timescale 1ns/1ns
module test_excitation_current_control_reg;
  logic clk_sys = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rd_valid, sfr_hit;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  ecc_pkg::ecc_conv_s main_conv_in = '0, aux_conv_in = '0, main_conv_out, aux_conv_out;
  logic [15:0] main_cal_word = 16'h8000, aux_cal_word = 16'h8000;
  logic source_one_on, source_two_on, source_one_pin_select, source_two_pin_select;
  logic main_conv_current_correction, aux_conv_current_correction, burnout_pos_on, burnout_neg_on;
  ecc_pkg::ecc_pin_s first_excitation_pin, second_excitation_pin;
  int error_cnt = 0, tests_run = 0;
  // Shared pin cases 0B and 07 give 400 on one pin; last value survives the unmapped write
  logic [7:0] vals [8] = '{8'hff, 8'h0b, 8'h07, 8'h0f, 8'h30, 8'h55, 8'haa, 8'h5a};

  ecc_ctrl dut
  (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_rd_valid(sfr_rd_valid),
    .sfr_hit(sfr_hit),
    .main_conv_in(main_conv_in),
    .aux_conv_in(aux_conv_in),
    .main_cal_word(main_cal_word),
    .aux_cal_word(aux_cal_word),
    .main_conv_out(main_conv_out),
    .aux_conv_out(aux_conv_out),
    .source_one_on(source_one_on),
    .source_two_on(source_two_on),
    .source_one_pin_select(source_one_pin_select),
    .source_two_pin_select(source_two_pin_select),
    .main_conv_current_correction(main_conv_current_correction),
    .aux_conv_current_correction(aux_conv_current_correction),
    .burnout_pos_on(burnout_pos_on),
    .burnout_neg_on(burnout_neg_on),
    .first_excitation_pin(first_excitation_pin),
    .second_excitation_pin(second_excitation_pin)
  );

  // ==========================================================
  // Clock and watchdog
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    check(1'b0, 1'b1, "run timeout");
    wrap_up();
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Strobe held one cycle; returns just after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    #1;
  endtask : wr

  // Bounded wait for the answer; a missing answer counts against hit
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
    logic got;
    got = 1'b0;
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      #1;
      if (sfr_rd_valid === 1'b1 && !got)
      begin
        got = 1'b1;
        check(sfr_rdata, exp, "read data");
      end
      @(posedge clk_sys);
    end
    // Address still stands here, so the decode output is settled
    check(sfr_hit, hit, "address hit");
    check(got, hit, "read answer");
  endtask : rd

  // Write, then compare controls, both pins and the read-back
  task automatic set_check(input logic [7:0] v);
    logic f1, f2, s1, s2;
    f1 = v[0] & ~v[2];
    f2 = v[1] & v[3];
    s1 = v[0] & v[2];
    s2 = v[1] & ~v[3];
    wr(8'hd5, v);
    check({burnout_neg_on, burnout_pos_on, aux_conv_current_correction, main_conv_current_correction,
      source_two_pin_select, source_one_pin_select, source_two_on, source_one_on}, {v[6], v[6:0]}, "controls");
    @(posedge clk_sys);
    #1;
    check(first_excitation_pin, {f1, f2, (f1 ? 10'h0c8 : 10'h000) + (f2 ? 10'h0c8 : 10'h000)}, "pin one");
    check(second_excitation_pin, {s1, s2, (s1 ? 10'h0c8 : 10'h000) + (s2 ? 10'h0c8 : 10'h000)}, "pin two");
    rd(8'hd5, {1'b0, v[6:0]}, 1'b1);
  endtask : set_check

  function automatic logic [15:0] scale(input logic [15:0] d, input logic [15:0] c);
    logic [31:0] p;
    p = ({16'h0000, d} * {16'h0000, c}) >> 15;
    return (p > 32'h0000_ffff) ? 16'hffff : p[15:0];
  endfunction : scale

  // Both result streams fed together; outputs due one cycle later
  task automatic conv(input logic [15:0] d, input logic [15:0] c, input logic [15:0] em, input logic [15:0] ea);
    @(posedge clk_sys);
    main_conv_in <= {1'b1, d};
    aux_conv_in <= {1'b1, d};
    main_cal_word <= c;
    aux_cal_word <= c;
    @(posedge clk_sys);
    main_conv_in.valid <= 1'b0;
    aux_conv_in.valid <= 1'b0;
    #1;
    check(main_conv_out, {1'b1, em}, "main result");
    check(aux_conv_out, {1'b1, ea}, "aux result");
  endtask : conv

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'hd5, 8'h00, 1'b1);
    check(first_excitation_pin, 12'h000, "pin at reset");
    $display("test reset done");
    foreach (vals[i]) set_check(vals[i]);
    $display("test fields done");
    wr(8'hd4, 8'h00);
    rd(8'hd5, 8'h5a, 1'b1);
    rd(8'hd6, 8'h00, 1'b0);
    $display("test unmapped done");
    // Reset in mid-run must clear a non-zero register and the first pin
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'hd5, 8'h00, 1'b1);
    check({burnout_neg_on, burnout_pos_on, aux_conv_current_correction, main_conv_current_correction,
      source_two_pin_select, source_one_pin_select, source_two_on, source_one_on}, 8'h00, "controls after reset");
    check(first_excitation_pin, 12'h000, "pin after reset");
    $display("test mid-run reset done");
    wr(8'hd5, 8'h20);
    conv(16'h1234, 16'h4000, 16'h1234, scale(16'h1234, 16'h4000));
    wr(8'hd5, 8'h10);
    // Saturated main result differs from the bypassed auxiliary one
    conv(16'hc000, 16'hffff, scale(16'hc000, 16'hffff), 16'hc000);
    $display("test correction done");
    wrap_up();
  end
endmodule : test_excitation_current_control_reg
